//--- bench/pcf_config_tb.sv
// Self-checking bench for the pulse-count flash configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h want %0h", $time, (g), (e)); end end
module pcf_config_tb;
  // Short counts keep the run brief; expectations derive from them
  localparam int LATCH = 20;
  localparam int OFF = 40;
  localparam int STEP = 100;
  logic clk_i = 1'b0;
  logic rst_n_i;
  logic trig;
  logic prog_pin;
  logic enabled, active, led_en;
  logic [3:0] lvl, ftime, ten, ratio;
  logic [9:0] permil;
  int miscompares = 0;
  int tests_run = 0;
  // Torch steps in tenths of a percent, flash ratios in thousandths
  int torch_tenths [16] = '{1000, 937, 874, 811, 748, 684, 621, 558,
                            495, 432, 369, 306, 243, 180, 117, 55};
  int ratio_permil [4] = '{1000, 840, 700, 620};

  // ==========================================================
  // Clock, design and host
  always #5 clk_i = ~clk_i;

  pcf_config #(.LATCH_CNT(LATCH), .OFF_CNT(OFF), .STEP_CNT(STEP)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .prog_pin_i(prog_pin), .flash_trigger_input_i(trig),
    .enabled_o(enabled), .torch_level_o(lvl), .flash_time_o(ftime), .torch_enable_o(ten),
    .flash_ratio_o(ratio), .flash_active_o(active), .led_enable_o(led_en), .led_permil_o(permil)
  );

  // Host defaults already equal LATCH and OFF above
  pcf_host_model host_u (.clk_i(clk_i), .pin_o(prog_pin));

  // ==========================================================
  // Closing and flash helpers
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Short flash; torch is off here, so only the flash can light the LED
  task automatic fire(input logic [9:0] want);
    trig = 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK(active, 1'b1)
    `CHK(led_en, 1'b1)
    `CHK(permil, want)
    trig = 1'b0;
    repeat (4) @(negedge clk_i);
    `CHK(active, 1'b0)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    trig = 1'b0;
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    `CHK(enabled, 1'b0)
    `CHK(lvl, 4'h1)
    `CHK(ftime, 4'h5)
    `CHK(ten, 4'h4)
    `CHK(ratio, 4'h1)
    // Data with no address goes to register zero; step 16 shows as zero
    for (int i = 1; i <= 16; i++) begin
      host_u.burst(i);
      `CHK(lvl, 4'(i))
      `CHK(led_en, 1'b1)
      `CHK(permil, 10'(torch_tenths[i - 1] / 7))
    end
    `CHK(enabled, 1'b1)
    // Torch enable codes, with an over-range value first
    host_u.burst(19);
    host_u.burst(5);
    `CHK(ten, 4'h4)
    for (int i = 1; i < 5; i++) begin
      host_u.burst(i);
      `CHK(ten, 4'(i))
      `CHK(led_en, (i > 2))
    end
    // An undefined address burst leaves the pointer alone
    host_u.burst(21);
    host_u.burst(2);
    `CHK(ten, 4'h2)
    host_u.burst(20, 1'b1);
    for (int i = 1; i < 5; i++) begin
      host_u.burst(i);
      `CHK(ratio, 4'(i))
      fire(10'(ratio_permil[i - 1]));
    end
    // Safety timer: refused code, shortest time, then disabled
    host_u.burst(18);
    host_u.burst(9);
    `CHK(ftime, 4'h5)
    host_u.burst(2);
    `CHK(ftime, 4'h2)
    trig = 1'b1;
    repeat (STEP * 6 / 10) @(negedge clk_i);
    `CHK(active, 1'b1)
    repeat (STEP * 6 / 10) @(negedge clk_i);
    `CHK(active, 1'b0)
    `CHK(led_en, 1'b0)
    trig = 1'b0;
    host_u.burst(1);
    trig = 1'b1;
    repeat (STEP * 3) @(negedge clk_i);
    `CHK(active, 1'b1)
    trig = 1'b0;
    // Shutdown clears data and pointer; torch comes back after wake-up
    host_u.shut_down();
    `CHK(enabled, 1'b0)
    `CHK(ftime, 4'h5)
    `CHK(ratio, 4'h1)
    `CHK(ten, 4'h4)
    // Mid-run reset with the pin low must leave the block shut down
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    `CHK(enabled, 1'b0)
    `CHK(lvl, 4'h1)
    host_u.burst(3);
    `CHK(lvl, 4'h3)
    `CHK(led_en, 1'b1)
    `CHK(permil, 10'(874 / 7))
    final_report();
  end

  // Whole sequence needs well under 20k cycles
  initial begin
    #(50_000 * 10);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire

//--- bench/pcf_host_model.sv
// Host model that drives the single programming pin by edge bursts
`timescale 1ns/1ns
`default_nettype none
module pcf_host_model #(
  parameter int LATCH_CNT = 20,
  parameter int OFF_CNT = 40
) (
  input wire logic clk_i,
  output logic pin_o
);
  // ==========================================================
  // Pin idles low, so the device stays shut down until a burst
  initial pin_o = 1'b0;

  // counted edges, one cycle low and one high each
  // high pause past the latch timeout; slow waits longer
  task automatic burst(input int n, input bit slow = 1'b0);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      pin_o = 1'b0;
      @(negedge clk_i);
      pin_o = 1'b1;
    end
    repeat (LATCH_CNT + 6 + (slow ? 3 * LATCH_CNT : 0)) @(negedge clk_i);
  endtask

  // hold the pin low past the shutdown timeout
  task automatic shut_down();
    @(negedge clk_i);
    pin_o = 1'b0;
    repeat (OFF_CNT + 6) @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

//--- hdl/pcf_config.sv
// Single-pin pulse-count configuration and flash/torch control
//
// What this block does
// - torch level 1..16 picks descending linear currents
// - timer data 1 off, 2..8 give 1..7 quarter seconds
// - enabled timer ends flash after programmed time
// - torch control 1,2 off; 3,4 on until a flash, then off until shutdown; default on
// - active flash enables LED regardless torch setting
// - flash ratio 1..4 gives 100/84/70/62 percent
// - torch maximum fixed at flash maximum over seven
// - pin low past timeout forces shutdown
// - shutdown clears all registers and address pointer
// - pin high past timeout latches counted burst
// - 17..20 edges select register; 1..16 data
// - first edge selects register zero; repeated writes
`timescale 1ns/1ns
`default_nettype none
module pcf_config
  import pcf_pkg::*;
#(
  parameter int LATCH_CNT = LATCH_CYCLES,
  parameter int OFF_CNT = OFF_CYCLES,
  parameter int STEP_CNT = STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic prog_pin_i,
  input wire logic flash_trigger_input_i,
  output logic enabled_o,
  output logic [3:0] torch_level_o,
  output logic [3:0] flash_time_o,
  output logic [3:0] torch_enable_o,
  output logic [3:0] flash_ratio_o,
  output logic flash_active_o,
  output logic led_enable_o,
  output logic [9:0] led_permil_o
);
  // ==========================================================
  // State
  logic pin_q, enabled, torch_blocked, trig_q;
  // Step 16 wraps to zero in four bits, so this flag marks a written level
  logic level_set, next_level_set;
  logic [4:0] edge_cnt;
  logic [1:0] addr;
  logic [3:0] regs [4];
  logic [31:0] high_cnt, low_cnt, step_cnt;
  logic [3:0] steps;
  pcf_flash_t flash_st;
  logic next_pin_q, next_enabled, next_torch_blocked, next_trig_q;
  logic [4:0] next_edge_cnt;
  logic [1:0] next_addr;
  logic [3:0] next_regs [4];
  logic [31:0] next_high_cnt, next_low_cnt, next_step_cnt;
  logic [3:0] next_steps;
  pcf_flash_t next_flash_st;
  logic next_led_enable;
  logic [9:0] next_led_permil;
  logic rise, latch_fire, off_fire, timer_done;
  logic [4:0] reg_max;
  logic [3:0] eff_level, eff_time, eff_en, eff_ratio;

  // Effective settings seen by the analog side
  assign eff_level = level_set ? regs[REG_TORCH_LEVEL] : DEF_TORCH_LEVEL;
  assign eff_time = pcf_eff(regs[REG_FLASH_TIME], DEF_FLASH_TIME);
  assign eff_en = pcf_eff(regs[REG_TORCH_EN], DEF_TORCH_EN);
  assign eff_ratio = pcf_eff(regs[REG_FLASH_RATIO], DEF_FLASH_RATIO);
  assign rise = prog_pin_i && !pin_q;
  assign latch_fire = pin_q && prog_pin_i && (edge_cnt != 5'h00) && (high_cnt == 32'(LATCH_CNT));
  assign off_fire = enabled && !prog_pin_i && (low_cnt == 32'(OFF_CNT));
  // data 1 disables, else (data-1) quarter steps
  assign timer_done = (eff_time != FLASH_TIME_OFF) && (steps == eff_time - 4'h1);

  // Largest data value each register accepts
  always_comb begin
    unique case (addr)
      REG_TORCH_LEVEL: reg_max = MAX_TORCH_LEVEL;
      REG_FLASH_TIME: reg_max = MAX_FLASH_TIME;
      REG_TORCH_EN: reg_max = MAX_TORCH_EN;
      REG_FLASH_RATIO: reg_max = MAX_FLASH_RATIO;
    endcase
  end

  // ==========================================================
  // Next-state logic for the pin decoder and flash sequencer
  always_comb begin
    next_pin_q = prog_pin_i;
    next_trig_q = flash_trigger_input_i;
    next_enabled = enabled;
    next_edge_cnt = edge_cnt;
    next_addr = addr;
    next_regs = regs;
    next_torch_blocked = torch_blocked;
    next_level_set = level_set;
    next_flash_st = flash_st;
    next_step_cnt = step_cnt;
    next_steps = steps;
    // Counters saturate so a parked pin never wraps into a false event
    next_high_cnt = prog_pin_i ? ((high_cnt == 32'(LATCH_CNT)) ? high_cnt : high_cnt + 32'h1) : 32'h0;
    next_low_cnt = !prog_pin_i ? ((low_cnt == 32'(OFF_CNT)) ? low_cnt : low_cnt + 32'h1) : 32'h0;
    if (rise) begin
      // waking edge with pointer at zero
      next_enabled = 1'b1;
      next_high_cnt = 32'h0;
      if (edge_cnt != EDGE_CNT_SAT) begin
        next_edge_cnt = edge_cnt + 5'h1;
      end
    end
    if (latch_fire) begin
      next_edge_cnt = 5'h00;
      if (edge_cnt >= ADDR_BURST_FIRST && edge_cnt <= ADDR_BURST_LAST) begin
        next_addr = 2'(edge_cnt - ADDR_BURST_FIRST);
      end else if (edge_cnt <= DATA_BURST_MAX) begin
        // data beyond the register range is dropped
        if (edge_cnt <= reg_max) begin
          next_regs[addr] = edge_cnt[3:0];
          // level 16 is kept as zero with the flag set
          if (addr == REG_TORCH_LEVEL) begin
            next_level_set = 1'b1;
          end
        end
      end
    end
    // Flash sequencer; a raised trigger after expiry waits for release
    unique case (flash_st)
      PCF_FL_IDLE: begin
        next_step_cnt = 32'h0;
        next_steps = 4'h0;
        if (enabled && flash_trigger_input_i && !trig_q) begin
          next_flash_st = PCF_FL_ON;
          // Torch stays off after a flash until the next shutdown
          next_torch_blocked = 1'b1;
        end
      end
      PCF_FL_ON: begin
        if (!flash_trigger_input_i) begin
          next_flash_st = PCF_FL_IDLE;
        end else if (timer_done) begin
          next_flash_st = PCF_FL_EXPIRED;
        end else if (step_cnt == 32'(STEP_CNT - 1)) begin
          next_step_cnt = 32'h0;
          next_steps = steps + 4'h1;
        end else begin
          next_step_cnt = step_cnt + 32'h1;
        end
      end
      PCF_FL_EXPIRED: begin
        if (!flash_trigger_input_i) begin
          next_flash_st = PCF_FL_IDLE;
        end
      end
      default: next_flash_st = PCF_FL_IDLE;
    endcase
    if (off_fire) begin
      next_enabled = 1'b0;
      next_addr = 2'h0;
      next_edge_cnt = 5'h00;
      next_regs = '{default: 4'h0};
      next_level_set = 1'b0;
      next_torch_blocked = 1'b0;
      next_flash_st = PCF_FL_IDLE;
    end
    // flash drives the LED whatever the torch setting
    // torch codes 3 and 4 mean on
    next_led_enable = enabled && ((flash_st == PCF_FL_ON) || (!torch_blocked && eff_en >= TORCH_ON_MIN));
    // flash peak ratio; torch scaled by one seventh
    if (flash_st == PCF_FL_ON) begin
      next_led_permil = pcf_ratio_permil(eff_ratio);
    end else if (next_led_enable) begin
      next_led_permil = pcf_torch_permil(eff_level) / TORCH_TO_FLASH_DIV;
    end else begin
      next_led_permil = 10'h000;
    end
  end

  // ==========================================================
  // Registers and registered outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_q <= 1'b0;
      trig_q <= 1'b0;
      enabled <= 1'b0;
      edge_cnt <= 5'h00;
      addr <= 2'h0;
      regs <= '{default: 4'h0};
      torch_blocked <= 1'b0;
      level_set <= 1'b0;
      flash_st <= PCF_FL_IDLE;
      high_cnt <= 32'h0;
      low_cnt <= 32'h0;
      step_cnt <= 32'h0;
      steps <= 4'h0;
      enabled_o <= 1'b0;
      torch_level_o <= 4'h0;
      flash_time_o <= 4'h0;
      torch_enable_o <= 4'h0;
      flash_ratio_o <= 4'h0;
      flash_active_o <= 1'b0;
      led_enable_o <= 1'b0;
      led_permil_o <= 10'h000;
    end else begin
      pin_q <= next_pin_q;
      trig_q <= next_trig_q;
      enabled <= next_enabled;
      edge_cnt <= next_edge_cnt;
      addr <= next_addr;
      regs <= next_regs;
      torch_blocked <= next_torch_blocked;
      level_set <= next_level_set;
      flash_st <= next_flash_st;
      high_cnt <= next_high_cnt;
      low_cnt <= next_low_cnt;
      step_cnt <= next_step_cnt;
      steps <= next_steps;
      enabled_o <= next_enabled;
      torch_level_o <= next_level_set ? next_regs[REG_TORCH_LEVEL] : DEF_TORCH_LEVEL;
      flash_time_o <= pcf_eff(next_regs[REG_FLASH_TIME], DEF_FLASH_TIME);
      torch_enable_o <= pcf_eff(next_regs[REG_TORCH_EN], DEF_TORCH_EN);
      flash_ratio_o <= pcf_eff(next_regs[REG_FLASH_RATIO], DEF_FLASH_RATIO);
      flash_active_o <= (next_flash_st == PCF_FL_ON);
      led_enable_o <= next_led_enable;
      led_permil_o <= next_led_permil;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_shutdown_entry: assert property (off_fire |=> !enabled && !enabled_o)
    else $error("shutdown not entered after long low");
  a_shutdown_clear: assert property (off_fire |=> addr == 2'h0 && regs[0] == 4'h0 && regs[3] == 4'h0)
    else $error("shutdown did not clear state");
  a_addr_decode: assert property (latch_fire && edge_cnt == 5'h12 |=> addr == 2'h1)
    else $error("18 edges did not select register 1");
  a_data_write: assert property (latch_fire && edge_cnt == 5'h02 && addr == 2'h1 |=> regs[1] == 4'h2 ##1 flash_time_o == 4'h2)
    else $error("data burst not written");
  a_range_ignore: assert property (latch_fire && addr == 2'h2 && edge_cnt > 5'h04 && edge_cnt <= 5'h10 |=> $stable(regs[2]))
    else $error("out of range data changed register");
  a_latch_wait: assert property (rise |=> !latch_fire [*2])
    else $error("burst latched without high pause");
  a_wake_edge: assert property (!enabled && rise |=> enabled && addr == 2'h0)
    else $error("first edge did not wake at register 0");
  a_flash_led: assert property (flash_st == PCF_FL_ON |=> led_enable_o)
    else $error("flash did not enable LED");
  a_torch_off: assert property (flash_st == PCF_FL_IDLE && eff_en < TORCH_ON_MIN && !off_fire |=> !led_enable_o)
    else $error("torch lit while disabled");
  a_timer_end: assert property (flash_st == PCF_FL_ON && flash_trigger_input_i && timer_done |=> flash_st == PCF_FL_EXPIRED ##1 !flash_active_o)
    else $error("safety timer did not end flash");
  a_ratio_level: assert property (flash_st == PCF_FL_ON && eff_ratio == 4'h2 |=> led_permil_o == 10'h348)
    else $error("flash ratio 84 percent wrong");
  a_torch_level: assert property (flash_st == PCF_FL_IDLE && next_led_enable && eff_level == 4'h1 |=> led_permil_o == 10'h08E)
    else $error("full torch is not one seventh of flash");
  a_lowest_step: assert property (latch_fire && addr == REG_TORCH_LEVEL && edge_cnt == DATA_BURST_MAX |=> level_set && torch_level_o == 4'h0)
    else $error("level 16 not kept as lowest step");

  c_addr_then_data: cover property (latch_fire && edge_cnt == 5'h13 ##[1:200] latch_fire && edge_cnt == 5'h01);
  c_shutdown: cover property (enabled ##1 off_fire ##1 !enabled);
  c_flash_expiry: cover property (flash_st == PCF_FL_ON ##1 flash_st == PCF_FL_EXPIRED);
endmodule
`default_nettype wire

//--- hdl/pcf_pkg.sv
// Constants and helper functions for the pulse-count flash configuration block
package pcf_pkg;
  // ==========================================================
  // Register indices (selected by edge bursts of 17..20)
  localparam logic [1:0] REG_TORCH_LEVEL = 2'h0;
  localparam logic [1:0] REG_FLASH_TIME = 2'h1;
  localparam logic [1:0] REG_TORCH_EN = 2'h2;
  localparam logic [1:0] REG_FLASH_RATIO = 2'h3;
  // ==========================================================
  // Burst decode
  localparam logic [4:0] ADDR_BURST_FIRST = 5'h11;
  localparam logic [4:0] ADDR_BURST_LAST = 5'h14;
  localparam logic [4:0] DATA_BURST_MAX = 5'h10;
  localparam logic [4:0] EDGE_CNT_SAT = 5'h1F;
  // Highest legal data per register
  localparam logic [4:0] MAX_TORCH_LEVEL = 5'h10;
  localparam logic [4:0] MAX_FLASH_TIME = 5'h08;
  localparam logic [4:0] MAX_TORCH_EN = 5'h04;
  localparam logic [4:0] MAX_FLASH_RATIO = 5'h04;
  // Defaults applied while a register still holds zero; torch level uses its default until first written
  localparam logic [3:0] DEF_TORCH_LEVEL = 4'h1;
  localparam logic [3:0] DEF_FLASH_TIME = 4'h5;
  localparam logic [3:0] DEF_TORCH_EN = 4'h4;
  localparam logic [3:0] DEF_FLASH_RATIO = 4'h1;
  localparam logic [3:0] FLASH_TIME_OFF = 4'h1;
  localparam logic [3:0] TORCH_ON_MIN = 4'h3;
  // ==========================================================
  // Timing
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BURST_LATCH_TIMEOUT_US = 500;
  localparam int SHUTDOWN_LOW_TIMEOUT_US = 500;
  localparam int FLASH_STEP_MS = 250;
  localparam int LATCH_CYCLES = BURST_LATCH_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int OFF_CYCLES = SHUTDOWN_LOW_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int STEP_CYCLES = FLASH_STEP_MS * (CLK_FREQ_HZ / 1000);
  // ==========================================================
  // Current scaling, in thousandths
  localparam logic [9:0] TORCH_TO_FLASH_DIV = 10'h007;
  localparam logic [9:0] FULL_PERMIL = 10'h3E8;

  typedef enum logic [1:0] {
    PCF_FL_IDLE = 2'b00,
    PCF_FL_ON = 2'b01,
    PCF_FL_EXPIRED = 2'b10
  } pcf_flash_t;

  // Torch step 1..16 as thousandths of maximum torch current
  function automatic logic [9:0] pcf_torch_permil(input logic [3:0] lvl);
    logic [9:0] v;
    v = 10'h000;
    case (lvl)
      4'h1: v = 10'h3E8;
      4'h2: v = 10'h3A9;
      4'h3: v = 10'h36A;
      4'h4: v = 10'h32B;
      4'h5: v = 10'h2EC;
      4'h6: v = 10'h2AC;
      4'h7: v = 10'h26D;
      4'h8: v = 10'h22E;
      4'h9: v = 10'h1EF;
      4'hA: v = 10'h1B0;
      4'hB: v = 10'h171;
      4'hC: v = 10'h132;
      4'hD: v = 10'h0F3;
      4'hE: v = 10'h0B4;
      4'hF: v = 10'h075;
      4'h0: v = 10'h037;
      default: v = 10'h000;
    endcase
    return v;
  endfunction

  // Flash ratio step 1..4 as thousandths of maximum flash current
  function automatic logic [9:0] pcf_ratio_permil(input logic [3:0] r);
    logic [9:0] v;
    v = 10'h3E8;
    case (r)
      4'h2: v = 10'h348;
      4'h3: v = 10'h2BC;
      4'h4: v = 10'h26C;
      default: v = 10'h3E8;
    endcase
    return v;
  endfunction

  // Zero means never written since shutdown, so the default applies
  function automatic logic [3:0] pcf_eff(input logic [3:0] v, input logic [3:0] d);
    return (v == 4'h0) ? d : v;
  endfunction
endpackage
